/* File: verilog/cpu_clock_select.sv */
// CPU clock selection, oscillator gating and peripheral clock enables.
//
// Overview of operation
// - Processor clock control resets to 02H
// - Bit 7 stops the main oscillator
// - Source and divide bits pick CPU clock
// - Shortest instruction spans two CPU clocks
// - Sub oscillator mode register resets to 00H
// - Bit 1 disconnects sub feedback resistor
// - Bit 0 stops the sub oscillator
// - Subclock control register resets to 00H
// - Bit 5 reports CPU running on subclock
// - Bit 4 selects sub or main source
// - Main oscillator held stopped during reset
// - Stop standby only allowed on main clock
// - Subclock reaches only the CPU, timers and LCD
// - Divider derives slow clocks from main clock
// - New selection waits for instruction boundary
`timescale 1ns/1ps
`default_nettype none

module cpu_clock_select
	import clk_gen_pkg::*;
(
	// Clock, reset and enable
	input  wire logic          core_clk_i,
	input  wire logic          reset_i,
	input  wire logic          ce_i,
	// Register access from the CPU
	input  wire reg_req_s      reg_req_i,
	output logic [7:0]         reg_rdata_o,
	// Oscillator pulses, one core cycle per oscillator period
	input  wire logic          main_osc_tick_i,
	input  wire logic          sub_osc_tick_i,
	// Oscillator controls
	output logic               main_osc_run_o,
	output logic               sub_osc_run_o,
	output logic               feedback_resistor_on_o,
	// CPU clock enable and instruction slot
	output logic               cpu_clk_en_o,
	output logic               instr_slot_o,
	output logic               cpu_on_sub_o,
	// Standby permissions
	output logic               stop_allowed_o,
	output logic               halt_allowed_o,
	// Peripheral clock enables
	output periph_ticks_s      periph_ticks_o
);

	// Programmable registers
	logic       main_osc_stop_ff;           // Main oscillator stop request
	logic       main_divide_select_ff;      // Slow main mode
	logic       feedback_resistor_off_ff;   // Sub feedback resistor disconnected
	logic       sub_osc_stop_ff;            // Sub oscillator stop request
	logic       cpu_source_select_ff;       // Requested CPU source
	logic       nxt_main_osc_stop;
	logic       nxt_main_divide_select;
	logic       nxt_feedback_resistor_off;
	logic       nxt_sub_osc_stop;
	logic       nxt_cpu_source_select;
	logic [7:0] rdata_ff;                   // Read data holding register
	logic [7:0] nxt_rdata;

	// Clocking state
	logic          act_src_ff;              // Source the CPU really runs on
	logic          act_div_ff;              // Divide ratio the CPU really uses
	logic [1:0]    div_cnt_ff;              // Main clock divide-by-four counter
	logic          sub_half_ff;             // Sub clock halving phase
	logic          slot_phase_ff;           // Second CPU clock of an instruction
	logic          main_run_ff;
	logic          sub_run_ff;
	logic          cpu_clk_ff;
	logic          slot_ff;
	logic          stop_ok_ff;
	periph_ticks_s ticks_ff;
	logic          nxt_act_src;
	logic          nxt_act_div;
	logic [1:0]    nxt_div_cnt;
	logic          nxt_sub_half;
	logic          nxt_slot_phase;
	logic          nxt_main_run;
	logic          nxt_sub_run;
	logic          nxt_cpu_clk;
	logic          nxt_slot;
	logic          nxt_stop_ok;
	periph_ticks_s nxt_ticks;

	// Gated oscillator pulses and derived ticks
	logic main_ok;
	logic sub_ok;
	logic div4_tick;
	logic sub_half_tick;
	logic cpu_tick;
	logic boundary;

	// Register writes and reads
	always_comb begin
		nxt_main_osc_stop         = main_osc_stop_ff;
		nxt_main_divide_select    = main_divide_select_ff;
		nxt_feedback_resistor_off = feedback_resistor_off_ff;
		nxt_sub_osc_stop          = sub_osc_stop_ff;
		nxt_cpu_source_select     = cpu_source_select_ff;
		nxt_rdata                 = rdata_ff;
		if (reg_req_i.wr) begin
			// Only the defined bits store; reserved bits are dropped
			case (reg_req_i.addr)
				ADDR_PROC_CLK_CTRL: begin
					nxt_main_osc_stop      = reg_req_i.wdata[BIT_MAIN_OSC_STOP];
					nxt_main_divide_select = reg_req_i.wdata[BIT_MAIN_DIV_SEL];
				end
				ADDR_SUB_OSC_MODE: begin
					nxt_feedback_resistor_off = reg_req_i.wdata[BIT_FEEDBACK_OFF];
					nxt_sub_osc_stop          = reg_req_i.wdata[BIT_SUB_OSC_STOP];
				end
				ADDR_SUBCLK_CTRL: begin
					// Status bit is read only, only the select stores
					nxt_cpu_source_select = reg_req_i.wdata[BIT_CPU_SRC_SEL];
				end
				default: begin
					// Other addresses belong to other blocks
				end
			endcase
		end
		if (reg_req_i.rd) begin
			nxt_rdata = 8'h00;
			case (reg_req_i.addr)
				ADDR_PROC_CLK_CTRL: begin
					nxt_rdata[BIT_MAIN_OSC_STOP] = main_osc_stop_ff;
					nxt_rdata[BIT_MAIN_DIV_SEL]  = main_divide_select_ff;
				end
				ADDR_SUB_OSC_MODE: begin
					nxt_rdata[BIT_FEEDBACK_OFF] = feedback_resistor_off_ff;
					nxt_rdata[BIT_SUB_OSC_STOP] = sub_osc_stop_ff;
				end
				ADDR_SUBCLK_CTRL: begin
					nxt_rdata[BIT_CPU_ON_SUB_STAT] = act_src_ff;
					nxt_rdata[BIT_CPU_SRC_SEL]     = cpu_source_select_ff;
				end
				default: begin
					nxt_rdata = 8'h00;
				end
			endcase
		end
	end

	// Register state; the enable freezes everything
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			main_osc_stop_ff         <= RST_PROC_CLK_CTRL[BIT_MAIN_OSC_STOP];
			main_divide_select_ff    <= RST_PROC_CLK_CTRL[BIT_MAIN_DIV_SEL];
			feedback_resistor_off_ff <= RST_SUB_OSC_MODE[BIT_FEEDBACK_OFF];
			sub_osc_stop_ff          <= RST_SUB_OSC_MODE[BIT_SUB_OSC_STOP];
			cpu_source_select_ff     <= RST_SUBCLK_CTRL[BIT_CPU_SRC_SEL];
			rdata_ff                 <= 8'h00;
		end else if (ce_i) begin
			main_osc_stop_ff         <= nxt_main_osc_stop;
			main_divide_select_ff    <= nxt_main_divide_select;
			feedback_resistor_off_ff <= nxt_feedback_resistor_off;
			sub_osc_stop_ff          <= nxt_sub_osc_stop;
			cpu_source_select_ff     <= nxt_cpu_source_select;
			rdata_ff                 <= nxt_rdata;
		end
	end

	// Oscillator pulses count only while the oscillator is let run
	assign main_ok       = main_osc_tick_i & main_run_ff;
	assign sub_ok        = sub_osc_tick_i & sub_run_ff;
	assign div4_tick     = main_ok & (div_cnt_ff == MAIN_DIV_LAST);
	assign sub_half_tick = sub_ok & sub_half_ff;
	// Source 1 ignores the divide bit, so 11 behaves as sub/2
	assign cpu_tick      = act_src_ff ? sub_half_tick
	                     : (act_div_ff ? div4_tick : main_ok);
	// Switching only after the second CPU clock of an instruction keeps every pulse whole
	assign boundary      = cpu_tick & slot_phase_ff;

	// Dividers, active selection and output enables
	always_comb begin
		nxt_div_cnt    = main_ok ? div_cnt_ff + 2'h1 : div_cnt_ff;
		nxt_sub_half   = sub_ok ? ~sub_half_ff : sub_half_ff;
		nxt_slot_phase = cpu_tick ? ~slot_phase_ff : slot_phase_ff;
		nxt_act_src    = act_src_ff;
		nxt_act_div    = act_div_ff;
		// Old clock keeps running until the instruction ends
		if (boundary) begin
			nxt_act_src = cpu_source_select_ff;
			nxt_act_div = main_divide_select_ff;
		end
		nxt_main_run   = ~main_osc_stop_ff;
		nxt_sub_run    = ~sub_osc_stop_ff;
		nxt_cpu_clk    = cpu_tick;
		nxt_slot       = boundary;
		nxt_stop_ok    = ~act_src_ff;
		// Timers, watch timer and LCD get the sub pulse; the rest run off main
		nxt_ticks.main_full  = main_ok;
		nxt_ticks.main_div4  = div4_tick;
		nxt_ticks.sub_timers = sub_ok;
	end

	// Clocking state registers
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			act_src_ff    <= RST_SUBCLK_CTRL[BIT_CPU_SRC_SEL];
			act_div_ff    <= RST_PROC_CLK_CTRL[BIT_MAIN_DIV_SEL];
			div_cnt_ff    <= 2'h0;
			sub_half_ff   <= 1'b0;
			slot_phase_ff <= 1'b0;
			main_run_ff   <= 1'b0;
			sub_run_ff    <= 1'b0;
			cpu_clk_ff    <= 1'b0;
			slot_ff       <= 1'b0;
			stop_ok_ff    <= 1'b1;
			ticks_ff      <= '0;
		end else if (ce_i) begin
			act_src_ff    <= nxt_act_src;
			act_div_ff    <= nxt_act_div;
			div_cnt_ff    <= nxt_div_cnt;
			sub_half_ff   <= nxt_sub_half;
			slot_phase_ff <= nxt_slot_phase;
			main_run_ff   <= nxt_main_run;
			sub_run_ff    <= nxt_sub_run;
			cpu_clk_ff    <= nxt_cpu_clk;
			slot_ff       <= nxt_slot;
			stop_ok_ff    <= nxt_stop_ok;
			ticks_ff      <= nxt_ticks;
		end
	end

	// Outputs from flip-flops, except the constant halt permission
	assign reg_rdata_o            = rdata_ff;
	assign main_osc_run_o         = main_run_ff;
	assign sub_osc_run_o          = sub_run_ff;
	assign feedback_resistor_on_o = ~feedback_resistor_off_ff;
	assign cpu_clk_en_o           = cpu_clk_ff;
	assign instr_slot_o           = slot_ff;
	assign cpu_on_sub_o           = act_src_ff;
	assign stop_allowed_o         = stop_ok_ff;
	assign halt_allowed_o         = 1'b1; // Halt is legal on either source
	assign periph_ticks_o         = ticks_ff;

	// Checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	a_main_gate: assert property (ce_i && main_osc_stop_ff |=> !main_osc_run_o)
		else $error("main oscillator runs while stopped");
	a_sub_gate: assert property (ce_i |=> sub_osc_run_o == !$past(sub_osc_stop_ff))
		else $error("sub oscillator gate wrong");
	a_fast_path: assert property (ce_i && !act_src_ff && !act_div_ff && main_ok
		|=> cpu_clk_en_o)
		else $error("full-rate main tick missing");
	a_sub_half: assert property (ce_i && act_src_ff && sub_ok && !sub_half_ff
		|=> !cpu_clk_en_o)
		else $error("sub clock not halved");
	a_div_wrap: assert property (ce_i && main_ok && div_cnt_ff == MAIN_DIV_LAST
		|=> periph_ticks_o.main_div4 && div_cnt_ff == 2'h0)
		else $error("divide by four wrong");
	a_slot_pair: assert property (instr_slot_o |-> cpu_clk_en_o)
		else $error("instruction slot without CPU clock");
	a_switch_boundary: assert property (ce_i && !boundary |=> $stable(act_src_ff)
		&& $stable(act_div_ff))
		else $error("selection changed mid instruction");
	a_status_read: assert property (ce_i && reg_req_i.rd && reg_req_i.addr == ADDR_SUBCLK_CTRL
		|=> reg_rdata_o[BIT_CPU_ON_SUB_STAT] == $past(act_src_ff))
		else $error("status bit wrong");
	a_reserved_zero: assert property (ce_i && reg_req_i.rd && reg_req_i.addr == ADDR_PROC_CLK_CTRL
		|=> reg_rdata_o[6:2] == 5'h00 && !reg_rdata_o[0])
		else $error("reserved bits not zero");
	a_stop_gate: assert property (ce_i && act_src_ff |=> !stop_allowed_o)
		else $error("stop allowed on sub clock");
	a_sub_only_timers: assert property (ce_i && sub_ok |=> periph_ticks_o.sub_timers)
		else $error("sub tick not forwarded");

	c_to_sub: cover property (boundary && !act_src_ff ##1 act_src_ff);
	c_main_stopped: cover property (act_src_ff && !main_osc_run_o);
	c_back_fast: cover property (act_div_ff && boundary ##1 !act_div_ff);
	c_sub_osc_off: cover property (!sub_osc_run_o && !feedback_resistor_on_o);

endmodule

`default_nettype wire

/* File: verilog/clk_gen_pkg.sv */
// Register map, field layout and reset values of the CPU clock generator.
package clk_gen_pkg;

	// Register addresses on the CPU data space
	localparam logic [15:0] ADDR_SUB_OSC_MODE  = 16'hfff0;
	localparam logic [15:0] ADDR_PROC_CLK_CTRL = 16'hfffb;
	localparam logic [15:0] ADDR_SUBCLK_CTRL   = 16'hfff2;

	// Reset values
	localparam logic [7:0] RST_PROC_CLK_CTRL = 8'h02;
	localparam logic [7:0] RST_SUB_OSC_MODE  = 8'h00;
	localparam logic [7:0] RST_SUBCLK_CTRL   = 8'h00;

	// Field positions
	localparam int unsigned BIT_MAIN_OSC_STOP   = 7;
	localparam int unsigned BIT_MAIN_DIV_SEL    = 1;
	localparam int unsigned BIT_FEEDBACK_OFF    = 1;
	localparam int unsigned BIT_SUB_OSC_STOP    = 0;
	localparam int unsigned BIT_CPU_ON_SUB_STAT = 5;
	localparam int unsigned BIT_CPU_SRC_SEL     = 4;

	// Main clock divider for the slow main mode
	localparam logic [1:0] MAIN_DIV_LAST = 2'h3;

	// CPU clocks per shortest instruction
	localparam int unsigned CPU_CLKS_PER_INSTR = 2;

	// CPU-side register access
	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} reg_req_s;

	// Clock enables handed to the peripherals
	typedef struct packed {
		logic main_full;
		logic main_div4;
		logic sub_timers;
	} periph_ticks_s;

endpackage

/* File: verification/osc_pair.sv */
// Behavioural model of the main and sub oscillators as tick sources.
`timescale 1ns/1ps
`default_nettype none

module osc_pair #(
	parameter int MAIN_PER = 3, // Core cycles per main oscillator period
	parameter int SUB_PER  = 8  // Core cycles per sub oscillator period
) (
	// Core clock and oscillator enables
	input  wire logic core_clk_i,
	input  wire logic main_run_i,
	input  wire logic sub_run_i,
	// One-cycle tick pulses
	output logic      main_tick_o,
	output logic      sub_tick_o
);
	int mc; // Main phase
	int sc; // Sub phase

	// Quiet outputs before the first edge
	initial begin
		main_tick_o = 1'b0;
		sub_tick_o = 1'b0;
		mc = 0;
		sc = 0;
	end

	// A stopped oscillator gives no ticks and freezes its phase
	always @(negedge core_clk_i) begin
		main_tick_o <= main_run_i && (mc == MAIN_PER - 1);
		sub_tick_o <= sub_run_i && (sc == SUB_PER - 1);
		if (main_run_i)
			mc <= (mc + 1) % MAIN_PER;
		if (sub_run_i)
			sc <= (sc + 1) % SUB_PER;
	end
endmodule

`default_nettype wire

/* File: verification/dual_oscillator_cpu_clock_select_bench.sv */
// Self-checking bench of the CPU clock selection block.
`timescale 1ns/1ps
`default_nettype none

module dual_oscillator_cpu_clock_select_bench
	import clk_gen_pkg::*;
;
	logic          core_clk_i = 1'b0;
	logic          reset_i = 1'b1;
	logic          ce_i = 1'b1;
	reg_req_s      req = '0;
	logic [7:0]    rdata;
	logic          mt, st, mrun, srun, fb, cen, slot, onsub, stopok, haltok;
	periph_ticks_s pt;
	logic [7:0]    c_cpu, c_slot, c_mf, c_m4, c_st; // Pulse counts in a window
	logic          cnt_on = 1'b0;
	logic [15:0]   seed = 16'h5bc1; // 23489
	int            errors = 0;
	int            n_checks = 0;
	int            cyc = 0;

	cpu_clock_select u_cpu_clock_select (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.ce_i(ce_i), .reg_req_i(req), .reg_rdata_o(rdata), .main_osc_tick_i(mt),
		.sub_osc_tick_i(st), .main_osc_run_o(mrun), .sub_osc_run_o(srun),
		.feedback_resistor_on_o(fb), .cpu_clk_en_o(cen), .instr_slot_o(slot),
		.cpu_on_sub_o(onsub), .stop_allowed_o(stopok), .halt_allowed_o(haltok),
		.periph_ticks_o(pt));
	osc_pair u_osc_pair (.core_clk_i(core_clk_i), .main_run_i(mrun), .sub_run_i(srun),
		.main_tick_o(mt), .sub_tick_o(st));

	// 40 MHz core clock
	initial begin
		forever #12.5 core_clk_i = ~core_clk_i;
	end

	// Window counters; 96 cycles hold whole periods of every rate
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			errors++;
			summarize();
		end
		if (cnt_on) begin
			c_cpu <= c_cpu + {7'h0, cen};
			c_slot <= c_slot + {7'h0, slot};
			c_mf <= c_mf + {7'h0, pt.main_full};
			c_m4 <= c_m4 + {7'h0, pt.main_div4};
			c_st <= c_st + {7'h0, pt.sub_timers};
		end
	end

	task automatic summarize();
		if (errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Register write, one-cycle strobe
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge core_clk_i);
		req.wr = 1'b0;
		@(negedge core_clk_i);
	endtask

	// Register read and compare; data holds until the next read
	task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] exp);
		req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge core_clk_i);
		req.rd = 1'b0;
		repeat (2) @(negedge core_clk_i);
		check(nm, rdata, exp);
	endtask

	// Let a new selection reach an instruction boundary, then count
	task automatic measure();
		repeat (64) @(negedge core_clk_i);
		{c_cpu, c_slot, c_mf, c_m4, c_st} = '0;
		cnt_on = 1'b1;
		repeat (96) @(negedge core_clk_i);
		cnt_on = 1'b0;
	endtask

	// CPU clocks in a window: bit 1 source, bit 0 divide
	function automatic logic [7:0] exp_cpu(input logic [1:0] m);
		return m[1] ? 8'h06 : (m[0] ? 8'h08 : 8'h20);
	endfunction

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	initial begin
		logic [1:0] m;
		repeat (10) @(negedge core_clk_i);
		check("main run in reset", {7'h0, mrun}, 8'h00);
		reset_i = 1'b0;
		@(negedge core_clk_i);
		check("main run", {7'h0, mrun}, 8'h01);
		check("sub run", {7'h0, srun}, 8'h01);
		check("feedback on", {7'h0, fb}, 8'h01);
		rchk("pcc reset", ADDR_PROC_CLK_CTRL, 8'h02);
		rchk("sub_oscillator_mode reset", ADDR_SUB_OSC_MODE, 8'h00);
		rchk("css reset", ADDR_SUBCLK_CTRL, 8'h00);
		rchk("unmapped", 16'hfff1, 8'h00);
		// Frozen block ignores a write
		ce_i = 1'b0;
		wr(ADDR_PROC_CLK_CTRL, 8'h00);
		ce_i = 1'b1;
		rchk("pcc frozen", ADDR_PROC_CLK_CTRL, 8'h02);
		// Every source and divide combination, the unlisted one last
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr(ADDR_PROC_CLK_CTRL, {6'h0, m[0], 1'b0});
			wr(ADDR_SUBCLK_CTRL, {3'h0, m[1], 4'h0});
			measure();
			check("cpu clocks", c_cpu, exp_cpu(m));
			check("instr slots", c_slot, exp_cpu(m) >> 1);
			check("main ticks", c_mf, 8'h20);
			check("div4 ticks", c_m4, 8'h08);
			check("sub ticks", c_st, 8'h0c);
			check("on sub", {7'h0, onsub}, {7'h0, m[1]});
			check("stop ok", {7'h0, stopok}, {7'h0, ~m[1]});
			check("halt ok", {7'h0, haltok}, 8'h01);
			rchk("css status", ADDR_SUBCLK_CTRL, {2'h0, m[1], m[1], 4'h0});
		end
		// Stop main while on the subclock; timers keep running
		wr(ADDR_PROC_CLK_CTRL, 8'h82);
		measure();
		check("main stopped", {7'h0, mrun}, 8'h00);
		check("no main ticks", c_mf, 8'h00);
		check("no div4 ticks", c_m4, 8'h00);
		check("sub cpu", c_cpu, 8'h06);
		rchk("pcc stop", ADDR_PROC_CLK_CTRL, 8'h82);
		wr(ADDR_PROC_CLK_CTRL, 8'h02);
		wr(ADDR_SUBCLK_CTRL, 8'h00);
		// Sub clock must keep running until the CPU has really left it
		repeat (40) @(negedge core_clk_i);
		check("back on main", {7'h0, onsub}, 8'h00);
		// Sub oscillator and resistor off, reserved bits kept zero
		wr(ADDR_SUB_OSC_MODE, 8'h03);
		measure();
		rchk("sub_oscillator_mode stop", ADDR_SUB_OSC_MODE, 8'h03);
		check("feedback off", {7'h0, fb}, 8'h00);
		check("sub stopped", {7'h0, srun}, 8'h00);
		check("no sub ticks", c_st, 8'h00);
		check("main cpu", c_cpu, 8'h08);
		wr(ADDR_SUB_OSC_MODE, 8'h00);
		// Random legal values; read-back and unmapped space
		repeat (16) begin
			seed = lfsr(seed);
			wr(ADDR_PROC_CLK_CTRL, seed[7:0] & 8'h02);
			wr(ADDR_SUB_OSC_MODE, seed[15:8] & 8'h03);
			rchk("pcc rand", ADDR_PROC_CLK_CTRL, seed[7:0] & 8'h02);
			rchk("sub_oscillator_mode rand", ADDR_SUB_OSC_MODE, seed[15:8] & 8'h03);
			rchk("unmapped rand", {8'h00, seed[7:0]}, 8'h00);
		end
		summarize();
	end
endmodule

`default_nettype wire
